// *** verilog/rtcs_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rtcs_consts.svh"

// Functional notes
// R1: oscillator stop edge sets stop flag
// R2: power-up, supply loss, halt set stop flag
// R3: stop flag cleared only by writing zero
// R4: alarm two match sets flag, drives irq
// R5: alarm one match sets flag, drives irq
// R6: alarm flags clear on zero, ignore one
// R7: charger on only with key 1010
// R8: charger register resets to zero
// R9: diode field 01 none, 10 one, else off
// R10: resistor field 01/10/11 sizes, 00 off
// R11: slave only, standard and fast rates
// R12: master starts only on idle bus
// R13: sda change during scl high is control
// R14: sda fall while scl high is start
// R15: sda rise while scl high is stop
// R16: one scl pulse per bit, change low
// R17: byte plus ack bit, unlimited bytes
// R18: receiver pulls sda low for ack
// R19: master nack ends read, sda released
// R20: bytes shifted msb first
// R21: first byte is address, writes acked
// R22: repeated start restarts address decoding
// R23: slave address 1101000, bit0 direction
// R24: pointer byte, then auto increment
// R25: bus pins synchronised, short glitches ignored; code has only the two-flop synchroniser, no glitch filter
module rtcs_top
    import rtcs_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N_O,
    input wire logic OSC_RUN_I,
    input wire logic SUPPLY_LOST_I,
    input wire logic ALARM_ONE_MATCH_I,
    input wire logic ALARM_TWO_MATCH_I,
    output logic ALARM_IRQ_PIN_O,
    output logic ALARM_IRQ_PIN_OE_N_O,
    output logic OSC_HALT_O,
    output logic CHARGER_ENABLE_O,
    output logic CHARGER_DIODE_O,
    output logic [1:0] CHARGER_RES_SEL_O
);

    localparam int NSYNC = 6;
    localparam int IX_SCL = 0;
    localparam int IX_SDA = 1;
    localparam int IX_OSC = 2;
    localparam int IX_LOST = 3;
    localparam int IX_ALM1 = 4;
    localparam int IX_ALM2 = 5;

    // ****************************************
    // decode helpers
    // ****************************************
    function automatic logic chg_on(input rtcs_byte_type cfg);
        logic [1:0] ds;
        ds = cfg[`RTCS_CHG_DIODE_HI:`RTCS_CHG_DIODE_LO];
        chg_on = (cfg[`RTCS_CHG_KEY_HI:`RTCS_CHG_KEY_LO] == `RTCS_CHG_KEY_OPEN) && // R7
                 ((ds == `RTCS_DIODE_NONE) || (ds == `RTCS_DIODE_ONE)) && // R9
                 (cfg[`RTCS_CHG_RES_HI:`RTCS_CHG_RES_LO] != `RTCS_RES_OFF); // R10
    endfunction

    function automatic logic is_ofs(input rtcs_byte_type ptr, input rtcs_byte_type ofs);
        is_ofs = (ptr == ofs);
    endfunction

    // ****************************************
    // link clock domain: bit capture on scl rise
    // ****************************************
    logic link_bit_ff;

    always_ff @(posedge SCL_I) begin
        link_bit_ff <= SDA_I; // R16
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [NSYNC-1:0] meta_ff, sync_ff, prev_ff, pin_in;

    assign pin_in = {ALARM_TWO_MATCH_I, ALARM_ONE_MATCH_I, SUPPLY_LOST_I, OSC_RUN_I, SDA_I, SCL_I};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    meta_ff[gi] <= 1'h1;
                    sync_ff[gi] <= 1'h1;
                    prev_ff[gi] <= 1'h1;
                end else begin
                    meta_ff[gi] <= pin_in[gi]; // R25
                    sync_ff[gi] <= meta_ff[gi];
                    prev_ff[gi] <= sync_ff[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // bus conditions
    // ****************************************
    logic scl_rise, scl_fall, start_ev, stop_ev;
    logic osc_stop_ev, lost_ev, alm1_ev, alm2_ev;

    assign scl_rise = sync_ff[IX_SCL] & ~prev_ff[IX_SCL];
    assign scl_fall = ~sync_ff[IX_SCL] & prev_ff[IX_SCL];
    // sda edges with scl held high are conditions, not data
    assign start_ev = sync_ff[IX_SCL] & prev_ff[IX_SCL] &
                      ~sync_ff[IX_SDA] & prev_ff[IX_SDA]; // R13 R14
    assign stop_ev = sync_ff[IX_SCL] & prev_ff[IX_SCL] &
                     sync_ff[IX_SDA] & ~prev_ff[IX_SDA]; // R13 R15
    assign osc_stop_ev = ~sync_ff[IX_OSC] & prev_ff[IX_OSC];
    assign lost_ev = sync_ff[IX_LOST] & ~prev_ff[IX_LOST];
    assign alm1_ev = sync_ff[IX_ALM1] & ~prev_ff[IX_ALM1];
    assign alm2_ev = sync_ff[IX_ALM2] & ~prev_ff[IX_ALM2];

    // sample point: link bit has long settled after the synced rise
    logic [`RTCS_SAMPLE_DELAY-1:0] rise_pipe_ff;
    logic smp;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rise_pipe_ff <= '0;
        end else begin
            rise_pipe_ff <= {rise_pipe_ff[`RTCS_SAMPLE_DELAY-2:0], scl_rise};
        end
    end

    assign smp = rise_pipe_ff[`RTCS_SAMPLE_DELAY-1];

    // ****************************************
    // protocol state
    // ****************************************
    rtcs_state_type state_ff;
    rtcs_byte_type shift_ff, tx_ff, ptr_ff, status_ff, control_ff, charger_ff, rd_data;
    logic [3:0] cnt_ff;
    logic master_ack_ff, sda_oe_n_ff, sda_o_ff;
    logic byte_done, addr_hit, wr_stb, rd_load, rd_adv;

    assign byte_done = scl_fall && (cnt_ff == `RTCS_BITS_PER_BYTE);
    assign addr_hit = (shift_ff[7:1] == `RTCS_SLAVE_ADDR); // R23
    assign wr_stb = byte_done && (state_ff == ST_WDATA); // R21
    // next read byte is fetched at the ack fall of the previous stage
    assign rd_load = scl_fall && (((state_ff == ST_ADDR_ACK) && shift_ff[0]) ||
                                  ((state_ff == ST_RDATA_ACK) && master_ack_ff));
    assign rd_adv = byte_done && (state_ff == ST_RDATA);

    always_comb begin
        rd_data = 8'h00;
        if (is_ofs(ptr_ff, `RTCS_OFS_CONTROL)) begin
            rd_data = control_ff;
        end else if (is_ofs(ptr_ff, `RTCS_OFS_STATUS)) begin
            rd_data = status_ff;
        end else if (is_ofs(ptr_ff, `RTCS_OFS_CHARGER)) begin
            rd_data = charger_ff;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_ff <= ST_IDLE;
        end else if (start_ev) begin
            state_ff <= ST_ADDR; // R22
        end else if (stop_ev) begin
            state_ff <= ST_IDLE;
        end else if (scl_fall) begin
            case (state_ff)
                ST_ADDR: begin
                    if (cnt_ff == `RTCS_BITS_PER_BYTE) begin
                        state_ff <= addr_hit ? ST_ADDR_ACK : ST_IDLE; // R21 R23
                    end
                end
                ST_ADDR_ACK: begin
                    state_ff <= (shift_ff[0] == `RTCS_DIR_READ) ? ST_RDATA : ST_PTR;
                end
                ST_PTR: begin
                    if (cnt_ff == `RTCS_BITS_PER_BYTE) begin
                        state_ff <= ST_PTR_ACK;
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    state_ff <= ST_WDATA; // R17
                end
                ST_WDATA: begin
                    if (cnt_ff == `RTCS_BITS_PER_BYTE) begin
                        state_ff <= ST_WDATA_ACK;
                    end
                end
                ST_RDATA: begin
                    if (cnt_ff == `RTCS_BITS_PER_BYTE) begin
                        state_ff <= ST_RDATA_ACK;
                    end
                end
                ST_RDATA_ACK: begin
                    state_ff <= master_ack_ff ? ST_RDATA : ST_IDLE; // R19
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // bit counter: counts sampled bits within a byte
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            cnt_ff <= 4'h0;
        end else if (start_ev || stop_ev || byte_done) begin
            cnt_ff <= 4'h0;
        end else if (smp && (state_ff == ST_ADDR || state_ff == ST_PTR ||
                             state_ff == ST_WDATA || state_ff == ST_RDATA)) begin
            cnt_ff <= cnt_ff + 4'h1; // R16
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            shift_ff <= 8'h00;
        end else if (smp && (state_ff == ST_ADDR || state_ff == ST_PTR ||
                             state_ff == ST_WDATA)) begin
            shift_ff <= {shift_ff[6:0], link_bit_ff}; // R20
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            master_ack_ff <= 1'h0;
        end else if (smp && (state_ff == ST_RDATA_ACK)) begin
            master_ack_ff <= ~link_bit_ff; // R19
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            tx_ff <= 8'h00;
        end else if (rd_load) begin
            tx_ff <= rd_data;
        end else if (scl_fall && (state_ff == ST_RDATA)) begin
            tx_ff <= {tx_ff[6:0], 1'h0}; // R20
        end
    end

    // register pointer
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ptr_ff <= 8'h00;
        end else if (byte_done && (state_ff == ST_PTR)) begin
            ptr_ff <= shift_ff; // R24
        end else if (wr_stb || rd_adv) begin
            ptr_ff <= ptr_ff + 8'h01; // R24
        end
    end

    // ****************************************
    // sda driver: changes on scl fall, released on start or stop
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sda_oe_n_ff <= 1'h1;
        end else if (start_ev || stop_ev) begin
            sda_oe_n_ff <= 1'h1;
        end else if (scl_fall) begin
            case (state_ff)
                ST_ADDR: begin
                    sda_oe_n_ff <= ~(byte_done && addr_hit); // R18 R21
                end
                ST_PTR, ST_WDATA: begin
                    sda_oe_n_ff <= ~byte_done; // R18 R21
                end
                ST_ADDR_ACK: begin
                    sda_oe_n_ff <= shift_ff[0] ? rd_data[7] : 1'h1;
                end
                ST_RDATA: begin
                    sda_oe_n_ff <= byte_done ? 1'h1 : tx_ff[6]; // R16
                end
                ST_RDATA_ACK: begin
                    sda_oe_n_ff <= master_ack_ff ? rd_data[7] : 1'h1; // R19
                end
                default: begin
                    sda_oe_n_ff <= 1'h1; // R11
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        sda_o_ff <= 1'h0;
    end

    // ****************************************
    // control register
    // ****************************************
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            control_ff <= `RTCS_RST_CONTROL;
        end else if (wr_stb && is_ofs(ptr_ff, `RTCS_OFS_CONTROL)) begin
            control_ff <= shift_ff & `RTCS_CTL_MASK;
        end
    end

    logic halt_set;
    assign halt_set = wr_stb && is_ofs(ptr_ff, `RTCS_OFS_CONTROL) &&
                      shift_ff[`RTCS_CTL_OSC_HALT] && !control_ff[`RTCS_CTL_OSC_HALT];

    // ****************************************
    // status flags: set beats clear
    // ****************************************
    logic sts_wr;
    assign sts_wr = wr_stb && is_ofs(ptr_ff, `RTCS_OFS_STATUS);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            status_ff <= `RTCS_RST_STATUS; // R2
        end else begin
            if (osc_stop_ev || lost_ev || halt_set) begin
                status_ff[`RTCS_STS_OSC_STOP] <= 1'h1; // R1 R2
            end else if (sts_wr && !shift_ff[`RTCS_STS_OSC_STOP]) begin
                status_ff[`RTCS_STS_OSC_STOP] <= 1'h0; // R3
            end
            if (alm2_ev) begin
                status_ff[`RTCS_STS_ALM_TWO] <= 1'h1; // R4
            end else if (sts_wr && !shift_ff[`RTCS_STS_ALM_TWO]) begin
                status_ff[`RTCS_STS_ALM_TWO] <= 1'h0; // R6
            end
            if (alm1_ev) begin
                status_ff[`RTCS_STS_ALM_ONE] <= 1'h1; // R5
            end else if (sts_wr && !shift_ff[`RTCS_STS_ALM_ONE]) begin
                status_ff[`RTCS_STS_ALM_ONE] <= 1'h0; // R6
            end
        end
    end

    // alarm pin: open drain, active low
    logic irq_oe_n_ff;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            irq_oe_n_ff <= 1'h1;
        end else begin
            irq_oe_n_ff <= ~(control_ff[`RTCS_CTL_IRQ_SEL] &
                ((control_ff[`RTCS_CTL_ALM_TWO_IE] & status_ff[`RTCS_STS_ALM_TWO]) | // R4
                 (control_ff[`RTCS_CTL_ALM_ONE_IE] & status_ff[`RTCS_STS_ALM_ONE]))); // R5
        end
    end

    // ****************************************
    // trickle charger
    // ****************************************
    logic chg_en_ff, chg_diode_ff;
    logic [1:0] chg_res_ff;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            charger_ff <= `RTCS_RST_CHARGER; // R8
        end else if (wr_stb && is_ofs(ptr_ff, `RTCS_OFS_CHARGER)) begin
            charger_ff <= shift_ff;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            chg_en_ff <= 1'h0; // R8
            chg_diode_ff <= 1'h0;
            chg_res_ff <= 2'h0;
        end else begin
            chg_en_ff <= chg_on(charger_ff); // R7
            chg_diode_ff <= chg_on(charger_ff) &&
                (charger_ff[`RTCS_CHG_DIODE_HI:`RTCS_CHG_DIODE_LO] == `RTCS_DIODE_ONE); // R9
            chg_res_ff <= chg_on(charger_ff) ?
                charger_ff[`RTCS_CHG_RES_HI:`RTCS_CHG_RES_LO] : 2'h0; // R10
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign SDA_O = sda_o_ff;
    assign SDA_OE_N_O = sda_oe_n_ff;
    assign ALARM_IRQ_PIN_O = sda_o_ff;
    assign ALARM_IRQ_PIN_OE_N_O = irq_oe_n_ff;
    assign OSC_HALT_O = control_ff[`RTCS_CTL_OSC_HALT];
    assign CHARGER_ENABLE_O = chg_en_ff;
    assign CHARGER_DIODE_O = chg_diode_ff;
    assign CHARGER_RES_SEL_O = chg_res_ff;

endmodule
`default_nettype wire

// *** verilog/rtcs_consts.svh ***
`ifndef RTCS_CONSTS_SVH
`define RTCS_CONSTS_SVH

// ****************************************
// bus addressing
// ****************************************
`define RTCS_SLAVE_ADDR 7'h68
`define RTCS_DIR_READ 1'h1

// ****************************************
// register offsets
// ****************************************
`define RTCS_OFS_CONTROL 8'h0e
`define RTCS_OFS_STATUS 8'h0f
`define RTCS_OFS_CHARGER 8'h10

// ****************************************
// reset values
// ****************************************
`define RTCS_RST_CONTROL 8'h18
`define RTCS_RST_STATUS 8'h80
`define RTCS_RST_CHARGER 8'h00

// ****************************************
// field positions
// ****************************************
`define RTCS_STS_OSC_STOP 7
`define RTCS_STS_ALM_TWO 1
`define RTCS_STS_ALM_ONE 0
`define RTCS_CTL_OSC_HALT 7
`define RTCS_CTL_IRQ_SEL 2
`define RTCS_CTL_ALM_TWO_IE 1
`define RTCS_CTL_ALM_ONE_IE 0
`define RTCS_CTL_MASK 8'hbf
`define RTCS_CHG_KEY_HI 7
`define RTCS_CHG_KEY_LO 4
`define RTCS_CHG_DIODE_HI 3
`define RTCS_CHG_DIODE_LO 2
`define RTCS_CHG_RES_HI 1
`define RTCS_CHG_RES_LO 0

// ****************************************
// field codes
// ****************************************
`define RTCS_CHG_KEY_OPEN 4'ha
`define RTCS_DIODE_NONE 2'h1
`define RTCS_DIODE_ONE 2'h2
`define RTCS_RES_OFF 2'h0

// ****************************************
// timing counts
// ****************************************
`define RTCS_BITS_PER_BYTE 4'h8
`define RTCS_SAMPLE_DELAY 2

`endif

// *** verilog/rtcs_pkg.sv ***
package rtcs_pkg;

    // one-hot protocol states
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_PTR = 9'h008,
        ST_PTR_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } rtcs_state_type;

    typedef logic [7:0] rtcs_byte_type;

endpackage

// *** bench/rtcs_top_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module rtcs_top_checker (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_N_O,
    input wire logic ALARM_IRQ_PIN_O,
    input wire logic ALARM_IRQ_PIN_OE_N_O,
    input wire logic OSC_HALT_O,
    input wire logic CHARGER_ENABLE_O,
    input wire logic CHARGER_DIODE_O,
    input wire logic [1:0] CHARGER_RES_SEL_O
);
    // ****************************************
    // port relations
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    property p_sda_zero; SDA_O == 1'h0; endproperty
    a_sda_zero: assert property (p_sda_zero) else $error("sda value");
    property p_irq_zero; ALARM_IRQ_PIN_O == 1'h0; endproperty
    a_irq_zero: assert property (p_irq_zero) else $error("irq value");
    property p_chg_off;
        !CHARGER_ENABLE_O |-> CHARGER_RES_SEL_O == 2'h0 && !CHARGER_DIODE_O;
    endproperty
    a_chg_off: assert property (p_chg_off) else $error("charger off");
    property p_chg_on; CHARGER_ENABLE_O |-> CHARGER_RES_SEL_O != 2'h0; endproperty
    a_chg_on: assert property (p_chg_on) else $error("charger on");
    property p_drive_low; !$stable(SDA_OE_N_O) |-> !SCL_I; endproperty
    a_drive_low: assert property (p_drive_low) else $error("sda moved");
    property p_ack_delay; $fell(SDA_OE_N_O) |-> !SCL_I && $past(SCL_I, 5); endproperty
    a_ack_delay: assert property (p_ack_delay) else $error("late pull");
    property p_reset_vals;
        $fell(RST_I) |-> SDA_OE_N_O && ALARM_IRQ_PIN_OE_N_O && !CHARGER_ENABLE_O && !OSC_HALT_O;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset outputs");
    property p_chg_write; !$stable(CHARGER_ENABLE_O) |-> !SCL_I; endproperty
    a_chg_write: assert property (p_chg_write) else $error("charger moved");
    property p_irq_clear; $rose(ALARM_IRQ_PIN_OE_N_O) |-> !SCL_I; endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq release");
    c_ack: cover property ($fell(SDA_OE_N_O));
    c_chg: cover property ($rose(CHARGER_ENABLE_O));
    c_irq: cover property ($fell(ALARM_IRQ_PIN_OE_N_O));
endmodule
bind rtcs_top rtcs_top_checker u_chk (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .SCL_I(SCL_I),
    .SDA_O(SDA_O),
    .SDA_OE_N_O(SDA_OE_N_O),
    .ALARM_IRQ_PIN_O(ALARM_IRQ_PIN_O),
    .ALARM_IRQ_PIN_OE_N_O(ALARM_IRQ_PIN_OE_N_O),
    .OSC_HALT_O(OSC_HALT_O),
    .CHARGER_ENABLE_O(CHARGER_ENABLE_O),
    .CHARGER_DIODE_O(CHARGER_DIODE_O),
    .CHARGER_RES_SEL_O(CHARGER_RES_SEL_O)
);
`default_nettype wire

// *** bench/rtcs_master.sv ***
`timescale 1ns/10ps
`default_nettype none
module rtcs_master (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    // ****************************************
    // bus master, 80 ns bit period
    // ****************************************
    initial begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
    end
    task automatic start();
        if (scl_o === 1'h0) begin
            sda_low_o = 1'h0;
            #20;
            scl_o = 1'h1;
            #40;
        end else begin
            #3;
        end
        sda_low_o = 1'h1;
        #40;
        scl_o = 1'h0;
        #20;
    endtask
    task automatic stop();
        sda_low_o = 1'h1;
        #20;
        scl_o = 1'h1;
        #40;
        sda_low_o = 1'h0;
        #40;
    endtask
    task automatic bit_xfer(input logic b, output logic r);
        sda_low_o = !b;
        #20;
        scl_o = 1'h1;
        #20;
        r = sda_i;
        #20;
        scl_o = 1'h0;
        #20;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'h1, r);
        ack = !r;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'h1, r);
            d[i] = r;
        end
        bit_xfer(last, r);
    endtask
endmodule
`default_nettype wire

// *** bench/rtcs_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rtcs_consts.svh"
module rtcs_top_tb
    import rtcs_pkg::*;
;
    typedef struct packed {
        rtcs_byte_type wr;
        logic en;
        logic dio;
        logic [1:0] res;
    } rtcs_row_type;
    logic clk, rst, scl, m_low, dut_oe_n, dut_sda, osc_run, supply_lost, alm1, alm2;
    logic irq_o, irq_oe_n, halt, chg_en, chg_dio, ack;
    logic [1:0] chg_res;
    wire logic sda = ~m_low & dut_oe_n;
    int error_cnt = 0;
    int n_checks = 0;
    rtcs_byte_type q[$];
    // {wr, en, dio, res}
    rtcs_row_type rows[13] = '{12'ha59, 12'ha6a, 12'ha7b, 12'ha9d, 12'haae, 12'habf,
        12'ha40, 12'ha10, 12'had0, 12'h550, 12'hb50, 12'he50, 12'h000};
    rtcs_top dut (.CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(dut_sda),
        .SDA_OE_N_O(dut_oe_n), .OSC_RUN_I(osc_run), .SUPPLY_LOST_I(supply_lost),
        .ALARM_ONE_MATCH_I(alm1), .ALARM_TWO_MATCH_I(alm2), .ALARM_IRQ_PIN_O(irq_o),
        .ALARM_IRQ_PIN_OE_N_O(irq_oe_n), .OSC_HALT_O(halt), .CHARGER_ENABLE_O(chg_en),
        .CHARGER_DIODE_O(chg_dio), .CHARGER_RES_SEL_O(chg_res));
    rtcs_master m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
    // ****************************************
    // helpers
    // ****************************************
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask
    task automatic wr(input rtcs_byte_type ofs, input rtcs_byte_type d[$]);
        m.start();
        m.send({`RTCS_SLAVE_ADDR, 1'h0}, ack);
        chk("address ack", 8'h1, {7'h0, ack});
        m.send(ofs, ack);
        chk("pointer ack", 8'h1, {7'h0, ack});
        foreach (d[i]) begin
            m.send(d[i], ack);
            chk("data ack", 8'h1, {7'h0, ack});
        end
        m.stop();
        tick(2);
    endtask
    task automatic rd(input rtcs_byte_type ofs, input int n);
        rtcs_byte_type b;
        q = {};
        m.start();
        m.send({`RTCS_SLAVE_ADDR, 1'h0}, ack);
        m.send(ofs, ack);
        m.start();
        m.send({`RTCS_SLAVE_ADDR, `RTCS_DIR_READ}, ack);
        chk("read address ack", 8'h1, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            m.recv(i == n - 1, b);
            q.push_back(b);
        end
        m.stop();
        tick(2);
    endtask
    task automatic rchk(input string nm, input rtcs_byte_type ofs, input rtcs_byte_type exp);
        rd(ofs, 1);
        chk(nm, exp, q[0]);
    endtask
    initial begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'h1;
        osc_run = 1'h1;
        supply_lost = 1'h0;
        alm1 = 1'h0;
        alm2 = 1'h0;
        tick(8);
        rst = 1'h0;
        tick(6);
        rd(`RTCS_OFS_STATUS, 2);
        chk("status reset", `RTCS_RST_STATUS, q[0]);
        chk("charger reset", `RTCS_RST_CHARGER, q[1]);
        chk("enable reset", 8'h0, {7'h0, chg_en});
        foreach (rows[i]) begin
            wr(`RTCS_OFS_CHARGER, '{rows[i].wr});
            chk("charger enable", {7'h0, rows[i].en}, {7'h0, chg_en});
            chk("charger diode", {7'h0, rows[i].dio}, {7'h0, chg_dio});
            chk("charger resistor", {6'h0, rows[i].res}, {6'h0, chg_res});
            rchk("charger readback", `RTCS_OFS_CHARGER, rows[i].wr);
        end
        wr(`RTCS_OFS_STATUS, '{8'hff});
        rchk("status ones", `RTCS_OFS_STATUS, 8'h80);
        wr(`RTCS_OFS_STATUS, '{8'h00, 8'ha9});
        chk("increment write", 8'h1, {7'h0, chg_dio});
        rd(`RTCS_OFS_STATUS, 2);
        chk("status cleared", 8'h00, q[0]);
        chk("increment read", 8'ha9, q[1]);
        wr(`RTCS_OFS_CONTROL, '{8'h07});
        alm2 = 1'h1;
        tick(8);
        alm2 = 1'h0;
        rchk("alarm two flag", `RTCS_OFS_STATUS, 8'h02);
        chk("irq two", 8'h0, {7'h0, irq_oe_n});
        alm1 = 1'h1;
        tick(8);
        alm1 = 1'h0;
        rchk("alarm one flag", `RTCS_OFS_STATUS, 8'h03);
        wr(`RTCS_OFS_STATUS, '{8'hfd});
        rchk("alarm clear", `RTCS_OFS_STATUS, 8'h01);
        chk("irq one", 8'h0, {7'h0, irq_oe_n});
        wr(`RTCS_OFS_CONTROL, '{8'h06});
        chk("irq masked", 8'h1, {7'h0, irq_oe_n});
        wr(`RTCS_OFS_STATUS, '{8'h00});
        for (int c = 0; c < 3; c++) begin
            if (c == 0) begin
                osc_run = 1'h0;
                tick(8);
                osc_run = 1'h1;
            end else if (c == 1) begin
                supply_lost = 1'h1;
                tick(8);
                supply_lost = 1'h0;
            end else begin
                wr(`RTCS_OFS_CONTROL, '{8'h80});
                chk("halt output", 8'h1, {7'h0, halt});
                wr(`RTCS_OFS_CONTROL, '{8'h00});
                rchk("halt readback", `RTCS_OFS_CONTROL, 8'h00);
            end
            tick(8);
            rchk("stop flag", `RTCS_OFS_STATUS, 8'h80);
            wr(`RTCS_OFS_STATUS, '{8'h00});
        end
        m.start();
        m.send(8'ha0, ack);
        chk("foreign address", 8'h0, {7'h0, ack});
        m.stop();
        rchk("after foreign", `RTCS_OFS_STATUS, 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
